// file: src/vdc_cc_decode.sv
`timescale 1ns/1ns
`default_nettype none
module vdc_cc_decode (
    input wire logic [1:0] role,
    input wire logic attach_result,
    input wire logic blank,
    input wire logic [1:0] src_code,
    input wire logic [1:0] snk_code,
    output logic [1:0] state
);
    // Role groups for one line
    wire role_quiet = (role == vdc_pkg::ROLE_RA) || (role == vdc_pkg::ROLE_OPEN);
    wire src_view = (role == vdc_pkg::ROLE_RP) || !attach_result;
    // Reserved source code never shown, reads as open
    wire [1:0] src_clean = (src_code == vdc_pkg::CC_SRC_RESERVED) ? vdc_pkg::CC_OPEN : src_code;

    // Blanking first, then quiet roles, then source or sink encoding
    // sink code otherwise
    assign state = (blank || role_quiet) ? vdc_pkg::CC_OPEN :
                   src_view ? src_clean : snk_code;
endmodule : vdc_cc_decode
`default_nettype wire

// file: src/vdc_pkg.sv
`default_nettype none
package vdc_pkg;
    // Register offsets on the register port
    localparam logic [7:0] SUPPLY_PATH_CONTROL_ADDR = 8'h1c;
    localparam logic [7:0] LINE_TERMINATION_STATUS_ADDR = 8'h1d;
    // Supply path control field positions
    localparam int PWR_VCONN_EN_BIT = 0;
    localparam int PWR_VCONN_CAP_BIT = 1;
    localparam int PWR_FORCE_DIS_BIT = 2;
    localparam int PWR_BLEED_DIS_BIT = 3;
    localparam int PWR_AUTO_DIS_BIT = 4;
    // Writable low bits and the constant read-only capability bit
    localparam logic [4:0] PWR_RW_MASK = 5'h1d;
    localparam logic [4:0] PWR_RESET = 5'h00;
    localparam logic PWR_VCONN_CAP_VALUE = 1'b1;
    // Line termination status field positions
    localparam int STS_SEARCH_BIT = 5;
    localparam int STS_ATTACH_BIT = 4;
    localparam int STS_CC2_LSB = 2;
    localparam int STS_CC1_LSB = 0;
    localparam logic [1:0] STS_RESERVED_VALUE = 2'h0;
    // Per-line role configuration codes
    localparam logic [1:0] ROLE_RA = 2'h0;
    localparam logic [1:0] ROLE_RP = 2'h1;
    localparam logic [1:0] ROLE_RD = 2'h2;
    localparam logic [1:0] ROLE_OPEN = 2'h3;
    // Line state codes
    localparam logic [1:0] CC_OPEN = 2'h0;
    localparam logic [1:0] CC_SRC_RESERVED = 2'h3;
    // Overcurrent limit codes
    localparam logic [1:0] OCP_400MA = 2'h0;
    localparam logic [1:0] OCP_600MA = 2'h1;
    localparam logic [1:0] OCP_800MA = 2'h2;
    localparam logic [1:0] OCP_RESERVED = 2'h3;
    // Width of the synchronised pin bundle
    localparam int SYNC_WIDTH = 10;
    // Auto discharge sequencer states
    typedef enum logic [1:0] {VDC_IDLE, VDC_DISCHARGE, VDC_DONE} vdc_state_e;
endpackage : vdc_pkg
`default_nettype wire

// file: src/vdc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module vdc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_reg;

    // Two flops per bit; multi-bit codes may skew by one cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : vdc_sync
`default_nettype wire

// file: src/vdc_top.sv
// Summary of operation
// - Source cut no later than discharge start
// - Sink with auto bit discharges on disconnect
// - Discharge stops below safe zero, bit kept
// - No discharge restart when VBUS rises again
// - Bit 3 enables bleed discharge
// - Bit 2 enables forced discharge
// - Bit 1 reads constant one
// - Two-bit code selects VCONN overcurrent limit
// - Bit 0 connects VCONN source
// - Status bits 7:6 read zero
// - Bit 5 shows connection search active
// - Bit 4 termination, updated when search ends
// - Source view encodes open, Ra, Rd
// - Sink view encodes open and current levels
// - Ra or open role reads CC2 zero
// - CC2 blanked during search or unflipped VCONN
// - CC1 same encodings, zero for quiet roles
// - CC1 blanked during search or VCONN flip
`timescale 1ns/1ns
`default_nettype none
module vdc_top (
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Same-clock state from the rest of the controller
    input wire logic connection_search_active,
    input wire logic presenting_rd,
    input wire logic source_mode,
    input wire logic source_request,
    input wire logic plug_flip_select,
    input wire logic [1:0] cc1_role,
    input wire logic [1:0] cc2_role,
    input wire logic [1:0] vconn_fault_config,
    // Analog comparator pins
    input wire logic disconnect_detect,
    input wire logic vbus_below_safe0,
    input wire logic [1:0] cc1_src_code,
    input wire logic [1:0] cc1_snk_code,
    input wire logic [1:0] cc2_src_code,
    input wire logic [1:0] cc2_snk_code,
    // Power path controls
    output logic vbus_source_en,
    output logic vbus_discharge_en,
    output logic vbus_bleed_en,
    output logic auto_discharge_active,
    output logic vconn_source_enable,
    output logic [1:0] vconn_ocp_limit_sel
);
    // Writable supply path control bits
    logic [4:0] pwr_reg;
    logic [4:0] pwr_next;
    // Search flag and its previous value
    logic search_reg;
    logic search_prev_reg;
    // Latched attach termination result
    logic attach_reg;
    // Auto discharge sequencer
    vdc_pkg::vdc_state_e state_reg;
    vdc_pkg::vdc_state_e state_next;
    // Disconnect edge tracking
    logic disc_prev_reg;
    // Synchronised pins
    logic [vdc_pkg::SYNC_WIDTH-1:0] pins_s;
    logic [1:0] cc1_state;
    logic [1:0] cc2_state;

    // All comparator pins cross into the clock domain here
    vdc_sync #(.WIDTH(vdc_pkg::SYNC_WIDTH)) u_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in({disconnect_detect, vbus_below_safe0, cc1_src_code, cc1_snk_code,
                   cc2_src_code, cc2_snk_code}),
        .sync_out(pins_s)
    );

    // Unpacked synchronised pins
    wire disc_s = pins_s[9];
    wire below_s = pins_s[8];
    wire [1:0] cc1_src_s = pins_s[7:6];
    wire [1:0] cc1_snk_s = pins_s[5:4];
    wire [1:0] cc2_src_s = pins_s[3:2];
    wire [1:0] cc2_snk_s = pins_s[1:0];

    // Control bit views
    wire auto_bit = pwr_reg[vdc_pkg::PWR_AUTO_DIS_BIT];
    wire bleed_bit = pwr_reg[vdc_pkg::PWR_BLEED_DIS_BIT];
    wire force_bit = pwr_reg[vdc_pkg::PWR_FORCE_DIS_BIT];
    wire vconn_bit = pwr_reg[vdc_pkg::PWR_VCONN_EN_BIT];

    // Register decode
    wire pwr_sel = (reg_addr == vdc_pkg::SUPPLY_PATH_CONTROL_ADDR);
    wire sts_sel = (reg_addr == vdc_pkg::LINE_TERMINATION_STATUS_ADDR);
    wire pwr_write = reg_wr && pwr_sel;

    // Only writable bits take the write data
    assign pwr_next = pwr_write ? (reg_wdata[4:0] & vdc_pkg::PWR_RW_MASK) : pwr_reg;

    // Disconnect event, in the first cycle the synced level is high
    wire disc_rise = disc_s && !disc_prev_reg;

    // Sequencer transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            vdc_pkg::VDC_IDLE: begin
                if (disc_rise && auto_bit) begin
                    state_next = vdc_pkg::VDC_DISCHARGE;
                end
            end
            vdc_pkg::VDC_DISCHARGE: begin
                if (below_s) begin
                    state_next = vdc_pkg::VDC_DONE;
                end
            end
            vdc_pkg::VDC_DONE: begin
                // Re-armed only by a new attach
                if (!disc_s) begin
                    state_next = vdc_pkg::VDC_IDLE;
                end
            end
            default: state_next = vdc_pkg::VDC_IDLE;
        endcase
    end

    // Discharge wanted in the coming cycle
    wire auto_next = (state_next == vdc_pkg::VDC_DISCHARGE);
    // Source path stays cut through discharge and until reattach
    wire cut_next = source_mode && (state_next != vdc_pkg::VDC_IDLE);

    // Overcurrent code, reserved falls back to the middle limit
    wire [1:0] ocp_next = (vconn_fault_config == vdc_pkg::OCP_RESERVED) ?
                          vdc_pkg::OCP_600MA : vconn_fault_config;

    wire blank2 = search_reg || (vconn_bit && !plug_flip_select);
    wire blank1 = search_reg || (vconn_bit && plug_flip_select);

    vdc_cc_decode u_cc2 (
        .role(cc2_role),
        .attach_result(attach_reg),
        .blank(blank2),
        .src_code(cc2_src_s),
        .snk_code(cc2_snk_s),
        .state(cc2_state)
    );

    vdc_cc_decode u_cc1 (
        .role(cc1_role),
        .attach_result(attach_reg),
        .blank(blank1),
        .src_code(cc1_src_s),
        .snk_code(cc1_snk_s),
        .state(cc1_state)
    );

    wire [7:0] status_word = {vdc_pkg::STS_RESERVED_VALUE, search_reg, attach_reg,
                              cc2_state, cc1_state};
    wire [7:0] pwr_word = {3'h0, pwr_reg[4:2], vdc_pkg::PWR_VCONN_CAP_VALUE,
                           pwr_reg[vdc_pkg::PWR_VCONN_EN_BIT]};
    // Unmapped reads return zero
    wire [7:0] rdata_next = !reg_rd ? reg_rdata : pwr_sel ? pwr_word :
                            sts_sel ? status_word : 8'h00;

    wire search_fell = search_prev_reg && !search_reg;
    wire attach_next = search_fell ? presenting_rd : attach_reg;

    // Configuration and read data
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pwr_reg <= vdc_pkg::PWR_RESET;
            reg_rdata <= 8'h00;
        end else begin
            pwr_reg <= pwr_next;
            reg_rdata <= rdata_next;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            search_reg <= 1'b0;
            search_prev_reg <= 1'b0;
            attach_reg <= 1'b0;
        end else begin
            search_reg <= connection_search_active;
            search_prev_reg <= search_reg;
            attach_reg <= attach_next;
        end
    end

    // Sequencer state and edge history
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= vdc_pkg::VDC_IDLE;
            disc_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            disc_prev_reg <= disc_s;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            vbus_source_en <= 1'b0;
            auto_discharge_active <= 1'b0;
            vbus_discharge_en <= 1'b0;
        end else begin
            vbus_source_en <= source_request && !cut_next;
            auto_discharge_active <= auto_next;
            vbus_discharge_en <= auto_next || force_bit;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            vbus_bleed_en <= 1'b0;
            vconn_source_enable <= 1'b0;
            vconn_ocp_limit_sel <= vdc_pkg::OCP_600MA;
        end else begin
            vbus_bleed_en <= bleed_bit;
            vconn_source_enable <= vconn_bit;
            vconn_ocp_limit_sel <= ocp_next;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // Auto bit clear means no discharge after disconnect
    auto_off_a: assert property (disc_rise && !auto_bit && state_reg == vdc_pkg::VDC_IDLE
        |=> !auto_discharge_active) else $error("auto discharge without enable");
    // Discharge never overlaps with sourcing
    src_cut_a: assert property (auto_discharge_active |-> !vbus_source_en)
        else $error("source still on during discharge");
    // Sink starts discharge on the next edge
    sink_start_a: assert property (disc_rise && auto_bit && !source_mode
        && state_reg == vdc_pkg::VDC_IDLE |=> auto_discharge_active && vbus_discharge_en)
        else $error("sink discharge missing");
    // Safe zero ends discharge and keeps the bit
    safe_stop_a: assert property (auto_discharge_active && below_s && !pwr_write
        |=> !auto_discharge_active && $stable(auto_bit))
        else $error("discharge not stopped");
    // Discharge only ever starts on a disconnect edge, never on VBUS rising
    no_restart_a: assert property (!auto_discharge_active && !disc_rise
        |=> !auto_discharge_active) else $error("discharge restarted");
    // Bleed output follows its bit
    bleed_path_a: assert property (##1 vbus_bleed_en == $past(bleed_bit))
        else $error("bleed output wrong");
    // Force bit drives discharge
    force_path_a: assert property (force_bit |=> vbus_discharge_en)
        else $error("forced discharge missing");
    // Capability bit reads one
    cap_read_a: assert property (reg_rd && pwr_sel |=> reg_rdata[vdc_pkg::PWR_VCONN_CAP_BIT])
        else $error("capability bit not one");
    // Limit code mapping
    ocp_map_a: assert property (vconn_fault_config == vdc_pkg::OCP_800MA
        |=> vconn_ocp_limit_sel == vdc_pkg::OCP_800MA) else $error("ocp code wrong");
    // VCONN source follows bit 0
    vconn_path_a: assert property (##1 vconn_source_enable == $past(vconn_bit))
        else $error("vconn enable wrong");
    // Reserved status bits zero
    sts_reserved_a: assert property (reg_rd && sts_sel |=> reg_rdata[7:6] == 2'h0)
        else $error("reserved bits set");
    // Search flag tracks its source one cycle later
    search_flag_a: assert property (connection_search_active |=> status_word[5])
        else $error("search flag missing");
    // Attach result captured at search end
    attach_latch_a: assert property (search_fell |=> attach_reg == $past(presenting_rd))
        else $error("attach result not latched");
    // Quiet CC2 role reads zero
    cc2_quiet_a: assert property (cc2_role == vdc_pkg::ROLE_RA |-> cc2_state == 2'h0)
        else $error("cc2 quiet role nonzero");
    // CC2 blanked
    cc2_blank_a: assert property (search_reg |-> cc2_state == 2'h0 && cc1_state == 2'h0)
        else $error("cc2 not blanked");
    // CC1 blanked on flipped VCONN
    cc1_blank_a: assert property (vconn_bit && plug_flip_select |-> cc1_state == 2'h0)
        else $error("cc1 not blanked");

    // Main scenarios
    src_seq_c: cover property (disc_rise && auto_bit && source_mode ##1 auto_discharge_active
        ##[1:50] !auto_discharge_active);
    sink_seq_c: cover property (disc_rise && auto_bit && !source_mode ##1 auto_discharge_active);
    attach_c: cover property (search_fell && presenting_rd);
    force_c: cover property (pwr_write && reg_wdata[vdc_pkg::PWR_FORCE_DIS_BIT]);
endmodule : vdc_top
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // Clock, reset and register port
    logic clock, nrst, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    // Controller state and comparator pins
    logic search, pres_rd, src_mode, src_req, flip, disc, safe0;
    logic [1:0] r1, r2, ocp, s1, k1, s2, k2, ocp_sel;
    // Power path outputs
    logic src_en, dis_en, bleed_en, auto_act, vconn_en;
    int n_fail = 0;
    int total_checks = 0;

    vdc_top dut_u (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .connection_search_active(search), .presenting_rd(pres_rd), .source_mode(src_mode),
        .source_request(src_req), .plug_flip_select(flip), .cc1_role(r1), .cc2_role(r2),
        .vconn_fault_config(ocp), .disconnect_detect(disc), .vbus_below_safe0(safe0),
        .cc1_src_code(s1), .cc1_snk_code(k1), .cc2_src_code(s2), .cc2_snk_code(k2),
        .vbus_source_en(src_en), .vbus_discharge_en(dis_en), .vbus_bleed_en(bleed_en),
        .auto_discharge_active(auto_act), .vconn_source_enable(vconn_en),
        .vconn_ocp_limit_sel(ocp_sel));
    vdc_mgr_model mgr_u (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

    // Free running clock, 4 ns period
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Let n edges pass, sample just after
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wt

    // Bounded wait for the auto sequence flag; the two-flop sync adds latency
    task automatic wait_auto(input logic lvl);
        for (int i = 0; i < 12 && auto_act !== lvl; i++) wt(1);
    endtask : wait_auto

    // Read status after sync settles
    task automatic rd_sts(input logic [7:0] exp);
        wt(4);
        mgr_u.read_reg(vdc_pkg::LINE_TERMINATION_STATUS_ADDR, rd);
        chk("status", rd, exp);
    endtask : rd_sts

    // Set roles and pin codes, then check status
    task automatic st(input logic [1:0] a, b, c, d, e, f, input logic [7:0] exp);
        @(posedge clock);
        r1 <= a;
        r2 <= b;
        s1 <= c;
        k1 <= d;
        s2 <= e;
        k2 <= f;
        rd_sts(exp);
    endtask : st

    // Counts, then verdict
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("Error watchdog expected finish seen hang");
        wrap_up();
    end

    // Main sequence
    initial begin
        nrst = 1'b0;
        {search, pres_rd, src_mode, src_req, flip, disc, safe0} = 7'h00;
        {r1, r2, s1, k1, s2, k2} = {vdc_pkg::ROLE_OPEN, vdc_pkg::ROLE_OPEN, 8'h00};
        ocp = 2'h0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        // Reset values, constant bit, unmapped place
        mgr_u.read_reg(vdc_pkg::SUPPLY_PATH_CONTROL_ADDR, rd);
        chk("power reset", rd, 8'h02);
        mgr_u.read_reg(8'h55, rd);
        chk("unmapped", rd, 8'h00);
        mgr_u.write_reg(vdc_pkg::SUPPLY_PATH_CONTROL_ADDR, 8'hfd);
        mgr_u.read_reg(vdc_pkg::SUPPLY_PATH_CONTROL_ADDR, rd);
        chk("power all", rd, 8'h1f);
        for (int i = 0; i < 5; i++) begin
            mgr_u.write_reg(vdc_pkg::SUPPLY_PATH_CONTROL_ADDR, 8'h01 << i);
            wt(2);
            chk("power pins", {bleed_en, dis_en, vconn_en}, {i == 3, i == 2, i == 0});
        end
        mgr_u.write_reg(vdc_pkg::LINE_TERMINATION_STATUS_ADDR, 8'hff);
        mgr_u.write_reg(vdc_pkg::SUPPLY_PATH_CONTROL_ADDR, 8'h00);
        rd_sts(8'h00);
        $display("test registers done");
        // Every overcurrent code, reserved falls back to 600mA
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            ocp <= i[1:0];
            wt(3);
            chk("ocp", ocp_sel, (i == 3) ? vdc_pkg::OCP_600MA : i[1:0]);
        end
        $display("test ocp done");
        // Source view with attach 0, then search blanks, attach latches on fall
        st(vdc_pkg::ROLE_RP, vdc_pkg::ROLE_RP, 2'h2, 2'h0, 2'h1, 2'h0, 8'h06);
        @(posedge clock);
        search <= 1'b1;
        pres_rd <= 1'b1;
        rd_sts(8'h20);
        @(posedge clock);
        search <= 1'b0;
        rd_sts(8'h16);
        @(posedge clock);
        pres_rd <= 1'b0;
        rd_sts(8'h16);
        st(vdc_pkg::ROLE_RD, vdc_pkg::ROLE_RD, 2'h0, 2'h3, 2'h0, 2'h2, 8'h1b);
        st(vdc_pkg::ROLE_RA, vdc_pkg::ROLE_OPEN, 2'h2, 2'h3, 2'h2, 2'h3, 8'h10);
        st(vdc_pkg::ROLE_RP, vdc_pkg::ROLE_RP, 2'h3, 2'h0, 2'h2, 2'h0, 8'h18);
        st(vdc_pkg::ROLE_RP, vdc_pkg::ROLE_RP, 2'h1, 2'h0, 2'h2, 2'h0, 8'h19);
        // VCONN on blanks the line under the plug
        mgr_u.write_reg(vdc_pkg::SUPPLY_PATH_CONTROL_ADDR, 8'h01);
        rd_sts(8'h11);
        @(posedge clock);
        flip <= 1'b1;
        rd_sts(8'h18);
        $display("test status done");
        // Source auto discharge: cut at discharge start, stop below safe zero, no restart
        mgr_u.write_reg(vdc_pkg::SUPPLY_PATH_CONTROL_ADDR, 8'h10);
        @(posedge clock);
        src_mode <= 1'b1;
        src_req <= 1'b1;
        wt(3);
        chk("source on", src_en, 1'b1);
        @(posedge clock);
        disc <= 1'b1;
        wait_auto(1'b1);
        chk("auto start", {auto_act, dis_en, src_en}, 3'b110);
        @(posedge clock);
        safe0 <= 1'b1;
        wait_auto(1'b0);
        chk("auto stop", {auto_act, dis_en}, 2'b00);
        mgr_u.read_reg(vdc_pkg::SUPPLY_PATH_CONTROL_ADDR, rd);
        chk("auto bit kept", rd, 8'h12);
        @(posedge clock);
        safe0 <= 1'b0;
        wt(10);
        chk("no restart", {auto_act, dis_en, src_en}, 3'b000);
        @(posedge clock);
        disc <= 1'b0;
        wt(5);
        chk("source back", src_en, 1'b1);
        // Sink auto discharge
        @(posedge clock);
        src_mode <= 1'b0;
        src_req <= 1'b0;
        wt(2);
        @(posedge clock);
        disc <= 1'b1;
        wait_auto(1'b1);
        chk("sink auto", {auto_act, dis_en, src_en}, 3'b110);
        @(posedge clock);
        safe0 <= 1'b1;
        wait_auto(1'b0);
        @(posedge clock);
        disc <= 1'b0;
        safe0 <= 1'b0;
        // Auto bit clear: disconnect does nothing
        mgr_u.write_reg(vdc_pkg::SUPPLY_PATH_CONTROL_ADDR, 8'h00);
        @(posedge clock);
        disc <= 1'b1;
        wt(10);
        chk("auto off", {auto_act, dis_en}, 2'b00);
        $display("test discharge done");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire

// file: test/vdc_mgr_model.sv
`timescale 1ns/1ns
`default_nettype none
// Port manager side of the register strobe port
module vdc_mgr_model (
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    // Quiet port at time zero
    initial begin
        reg_addr = 8'hff;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // One write strobe; released lines go inverted so stale data never looks valid
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask : write_reg

    // One read strobe; data lands on the edge that takes it
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = reg_rdata;
    endtask : read_reg
endmodule : vdc_mgr_model
`default_nettype wire
